// ===== rtl/adcseq_pkg.sv
// Package of constants and types for the ADC conversion sequencer.
package adcseq_pkg;

  // --------------------------------------------------------------------
  // Register byte addresses.
  // --------------------------------------------------------------------
  localparam logic [7:0] OFF_INPUT_SELECT = 8'h00;
  localparam logic [7:0] OFF_CTRL_A       = 8'h04;
  localparam logic [7:0] OFF_CTRL_B       = 8'h08;
  localparam logic [7:0] OFF_RESULT_LOW   = 8'h0C;
  localparam logic [7:0] OFF_RESULT_HIGH  = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h18;
  localparam logic [7:0] OFF_SAMPLE_IN    = 8'h1C;

  // --------------------------------------------------------------------
  // Field positions.
  // --------------------------------------------------------------------
  localparam int unsigned POS_REF_SEL    = 6;
  localparam int unsigned POS_LEFT_ALIGN = 5;
  localparam int unsigned POS_CHAN_SEL   = 0;
  localparam int unsigned POS_ENABLE     = 7;
  localparam int unsigned POS_START      = 6;
  localparam int unsigned POS_AUTO_TRIG  = 5;
  localparam int unsigned POS_DONE_FLAG  = 4;
  localparam int unsigned POS_DIV_SEL    = 0;
  localparam int unsigned POS_SYNC_HOLD  = 7;
  localparam int unsigned POS_TRIG_SRC   = 0;
  localparam int unsigned POS_IRQ_DONE   = 0;

  // --------------------------------------------------------------------
  // Reset values, encodings and timing.
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] INPUT_SEL_WMASK  = 8'hEF;
  localparam logic [7:0] RST_CTRL_A       = 8'h00;
  localparam logic [7:0] RST_CTRL_B       = 8'h00;
  localparam logic [3:0] TRIG_FREE_RUN    = 4'h0;
  localparam logic [3:0] TRIG_EXTERNAL    = 4'h1;
  localparam logic [3:0] CONV_CYCLES      = 4'hD;
  localparam logic [9:0] DIFF_MAX_POS     = 10'h1FF;
  localparam logic [9:0] DIFF_MAX_NEG     = 10'h200;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_CONVERT = 3'h2,
    ST_FINISH  = 3'h4
  } adcseq_state_t;

endpackage : adcseq_pkg

// ===== rtl/adcseq_top.sv
// ADC conversion sequencer with AXI4-Lite register slave.
`timescale 1ns/1ps

// Operation
// - With free-running trigger chosen, a new conversion starts at once after each one ends.
// - Free running continues whether or not the done flag was cleared.
// - A start-bit write begins a conversion even with auto-trigger on, a single one unless free running is chosen.
// - The start bit reads one during any conversion, however it was started.
// - A prescaler set by the divide field derives the converter clock.
// - Differential results are 10-bit two's complement from 0x200 to 0x1FF.
// - The result splits into a high byte of upper bits and a low byte.
// - The align bit set left-justifies the result, clear right-justifies.
// - Input select holds reference 7:6, align 5, read-only 4, channel 3:0.
// - With sync hold set, the sync signal is blocked until high byte read.
module adcseq_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [9:0]  sample_code,
  input  wire logic        ext_trigger,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             adc_clk_out,
  output logic [3:0]       channel_out,
  output logic             irq
);

  // --------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------
  adcseq_pkg::adcseq_state_t state_ff;
  logic [7:0]  in_sel_ff;
  logic        enable_ff;
  logic        start_ff;
  logic        auto_trig_ff;
  logic [2:0]  div_sel_ff;
  logic        sync_hold_ff;
  logic [3:0]  trig_src_ff;
  logic [9:0]  result_ff;
  logic        done_ff;
  logic        irq_mask_ff;
  logic        hold_ff;
  logic [6:0]  pre_cnt_ff;
  logic        adc_clk_ff;
  logic [3:0]  bit_cnt_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic        w_strb0_ff;
  logic [1:0]  ext_sync_ff;
  logic [1:0]  syn_sync_ff;
  logic        ext_prev_ff;
  logic [9:0]  code_s1_ff;
  logic [9:0]  code_s2_ff;
  logic        wr_fire;
  logic        rd_fire;
  logic        start_wr;
  logic        done_wr1;
  logic        conv_end;
  logic        adc_tick;
  logic        trig_hit;
  logic [15:0] res_word;
  logic [6:0]  div_limit;
  logic [31:0] rd_word;
  logic        rd_ok;

  // Returns the prescaler count limit, one less than the half-period, for a divide select code.
  function automatic logic [6:0] div_half(input logic [2:0] sel);
    logic [7:0] full;
    full = 8'h01 << ((sel == 3'h0) ? 3'h1 : sel);
    return full[7:1] - 7'h01;
  endfunction

  // Aligns a 10-bit result into a 16-bit high/low byte pair.
  function automatic logic [15:0] align_res(input logic [9:0] r,
                                            input logic       left);
    return left ? {r, 6'h00} : {6'h00, r};
  endfunction

  // --------------------------------------------------------------------
  // AXI4-Lite write channel.
  // --------------------------------------------------------------------
  assign wr_fire  = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign start_wr = wr_fire && (aw_addr_ff == adcseq_pkg::OFF_CTRL_A) &&
                    w_strb0_ff && w_data_ff[adcseq_pkg::POS_START];
  assign done_wr1 = wr_fire && (aw_addr_ff == adcseq_pkg::OFF_CTRL_A) &&
                    w_strb0_ff && w_data_ff[adcseq_pkg::POS_DONE_FLAG];

  // Address and data are latched independently; response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h0000_0000;
      w_strb0_ff    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= adcseq_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff   <= 1'b1;
        w_data_ff  <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_ff > adcseq_pkg::OFF_IRQ_MASK) ?
                        adcseq_pkg::RESP_SLVERR : adcseq_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_sel_ff    <= adcseq_pkg::RST_INPUT_SELECT;
      enable_ff    <= 1'b0;
      auto_trig_ff <= 1'b0;
      div_sel_ff   <= 3'h0;
      sync_hold_ff <= 1'b0;
      trig_src_ff  <= 4'h0;
      irq_mask_ff  <= 1'b0;
    end else if (wr_fire && w_strb0_ff) begin
      case (aw_addr_ff)
        adcseq_pkg::OFF_INPUT_SELECT: begin
          in_sel_ff <= w_data_ff[7:0] & adcseq_pkg::INPUT_SEL_WMASK;
        end
        adcseq_pkg::OFF_CTRL_A: begin
          enable_ff    <= w_data_ff[adcseq_pkg::POS_ENABLE];
          auto_trig_ff <= w_data_ff[adcseq_pkg::POS_AUTO_TRIG];
          div_sel_ff   <= w_data_ff[adcseq_pkg::POS_DIV_SEL +: 3];
        end
        adcseq_pkg::OFF_CTRL_B: begin
          sync_hold_ff <= w_data_ff[adcseq_pkg::POS_SYNC_HOLD];
          trig_src_ff  <= w_data_ff[adcseq_pkg::POS_TRIG_SRC +: 4];
        end
        adcseq_pkg::OFF_IRQ_MASK: begin
          irq_mask_ff <= w_data_ff[adcseq_pkg::POS_IRQ_DONE];
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read channel.
  // --------------------------------------------------------------------
  assign res_word = align_res(result_ff,
                              in_sel_ff[adcseq_pkg::POS_LEFT_ALIGN]);
  assign rd_fire  = s_axi_arvalid && s_axi_arready;

  // Read multiplexer of all mapped registers.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      adcseq_pkg::OFF_INPUT_SELECT: rd_word[7:0] = in_sel_ff;
      adcseq_pkg::OFF_CTRL_A: rd_word[7:0] = {enable_ff, start_ff,
        auto_trig_ff, done_ff, 1'b0, div_sel_ff};
      adcseq_pkg::OFF_CTRL_B: rd_word[7:0] = {sync_hold_ff, 3'h0, trig_src_ff};
      adcseq_pkg::OFF_RESULT_LOW: rd_word[7:0] = res_word[7:0];
      adcseq_pkg::OFF_RESULT_HIGH: rd_word[7:0] = res_word[15:8];
      adcseq_pkg::OFF_IRQ_STATUS: rd_word[0] = done_ff;
      adcseq_pkg::OFF_IRQ_MASK: rd_word[0] = irq_mask_ff;
      adcseq_pkg::OFF_SAMPLE_IN: rd_word[9:0] = code_s2_ff;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read address taken one cycle after valid; data one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= adcseq_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? adcseq_pkg::RESP_OKAY :
                                adcseq_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Input synchronisers.
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync_ff <= 2'b00;
      syn_sync_ff <= 2'b00;
      ext_prev_ff <= 1'b0;
      code_s1_ff  <= 10'h000;
      code_s2_ff  <= 10'h000;
    end else begin
      ext_sync_ff <= {ext_sync_ff[0], ext_trigger};
      syn_sync_ff <= {syn_sync_ff[0], sync_in};
      ext_prev_ff <= ext_sync_ff[1];
      code_s1_ff  <= sample_code;
      code_s2_ff  <= code_s1_ff;
    end
  end

  // --------------------------------------------------------------------
  // Prescaler producing the converter clock.
  // --------------------------------------------------------------------
  assign div_limit = div_half(div_sel_ff);
  assign adc_tick  = (pre_cnt_ff >= div_limit) && !adc_clk_ff;

  // Counts half-periods of the converter clock while enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_ff) begin
      pre_cnt_ff <= 7'h00;
      adc_clk_ff <= 1'b0;
    end else if (pre_cnt_ff >= div_limit) begin
      pre_cnt_ff <= 7'h00;
      adc_clk_ff <= !adc_clk_ff;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 7'h01;
    end
  end

  // --------------------------------------------------------------------
  // Conversion sequencer.
  // --------------------------------------------------------------------
  assign conv_end = (state_ff == adcseq_pkg::ST_FINISH);
  assign trig_hit = auto_trig_ff && (
      ((trig_src_ff == adcseq_pkg::TRIG_FREE_RUN) && conv_end) ||
      ((trig_src_ff == adcseq_pkg::TRIG_EXTERNAL) &&
       ext_sync_ff[1] && !ext_prev_ff));

  // Idle waits for a start, convert counts converter clocks.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_ff) begin
      state_ff   <= adcseq_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      result_ff  <= 10'h000;
    end else begin
      case (state_ff)
        adcseq_pkg::ST_IDLE: begin
          if (start_wr || trig_hit) begin
            state_ff   <= adcseq_pkg::ST_CONVERT;
            bit_cnt_ff <= 4'h0;
          end
        end
        adcseq_pkg::ST_CONVERT: begin
          if (adc_tick) begin
            if (bit_cnt_ff == adcseq_pkg::CONV_CYCLES - 4'h1) begin
              state_ff  <= adcseq_pkg::ST_FINISH;
              result_ff <= code_s2_ff;
            end
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        adcseq_pkg::ST_FINISH: begin
          // Free running restarts here regardless of the done flag.
          // A start written in this cycle is honoured, not lost.
          state_ff   <= (trig_hit || start_wr) ?
                        adcseq_pkg::ST_CONVERT : adcseq_pkg::ST_IDLE;
          bit_cnt_ff <= 4'h0;
        end
        default: state_ff <= adcseq_pkg::ST_IDLE;
      endcase
    end
  end

  // Start bit shows busy; set by software or trigger, cleared at end.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_ff) begin
      start_ff <= 1'b0;
    end else if (start_wr || (trig_hit &&
                 state_ff != adcseq_pkg::ST_CONVERT)) begin
      start_ff <= 1'b1;
    end else if (conv_end) begin
      start_ff <= 1'b0;
    end
  end

  // Done flag: set wins over a write-one clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_ff <= 1'b0;
    end else if (conv_end) begin
      done_ff <= 1'b1;
    end else if (done_wr1 || (wr_fire && w_strb0_ff &&
                 aw_addr_ff == adcseq_pkg::OFF_IRQ_STATUS &&
                 w_data_ff[adcseq_pkg::POS_IRQ_DONE])) begin
      done_ff <= 1'b0;
    end
  end

  // Sync hold: blocks sync from a conversion end until high byte read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_ff <= 1'b0;
    end else if (conv_end && sync_hold_ff) begin
      hold_ff <= 1'b1;
    end else if (rd_fire && ({s_axi_araddr[7:2], 2'b00} ==
                 adcseq_pkg::OFF_RESULT_HIGH)) begin
      hold_ff <= 1'b0;
    end
  end

  // Registered outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out    <= 1'b0;
      adc_clk_out <= 1'b0;
      channel_out <= 4'h0;
      irq         <= 1'b0;
    end else begin
      sync_out    <= syn_sync_ff[1] && !(hold_ff && sync_hold_ff);
      adc_clk_out <= adc_clk_ff;
      channel_out <= in_sel_ff[adcseq_pkg::POS_CHAN_SEL +: 4];
      irq         <= done_ff && irq_mask_ff;
    end
  end

  // --------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------
  a_busy_in_conv: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_ff == adcseq_pkg::ST_CONVERT) |-> start_ff)
    else $error("start bit low during conversion");
  a_done_at_end: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_end |=> done_ff)
    else $error("done flag not set at end");
  a_free_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_end && auto_trig_ff && enable_ff &&
     trig_src_ff == adcseq_pkg::TRIG_FREE_RUN)
    |=> (state_ff == adcseq_pkg::ST_CONVERT))
    else $error("free running did not restart");
  a_sw_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_wr && enable_ff && state_ff == adcseq_pkg::ST_IDLE)
    |=> (state_ff == adcseq_pkg::ST_CONVERT) && start_ff)
    else $error("software start ignored");
  a_single_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_end && !auto_trig_ff && !start_wr) |=> !start_ff)
    else $error("start bit not cleared");
  a_sync_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (hold_ff && sync_hold_ff) |=> !sync_out)
    else $error("sync passed while held");
  a_sel_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_sel_ff[4])
    else $error("reserved select bit set");
  a_left_align: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_fire && in_sel_ff[adcseq_pkg::POS_LEFT_ALIGN] &&
     ({s_axi_araddr[7:2], 2'h0} == adcseq_pkg::OFF_RESULT_HIGH))
    |=> ({s_axi_rdata[7:0], 2'h0} == ($past(result_ff) & 10'h3FC)))
    else $error("left alignment wrong");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_ff && irq_mask_ff) |=> irq)
    else $error("unmasked done gave no irq");

endmodule // adcseq_top

// ===== sim/tb_top.sv
// Self-checking testbench for the ADC conversion sequencer.
`timescale 1ns/1ps

module tb_top;

  // --------------------------------------------------------------------
  // Signals driven into and seen from the design.
  // --------------------------------------------------------------------
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic [9:0]  sample_code   = 10'h000;
  logic        ext_trigger   = 1'b0;
  logic        sync_in       = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        sync_out, adc_clk_out, irq;
  logic [3:0]  channel_out;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc         = 0;
  logic [1:0]  bq [$];
  logic [65:0] rq [$];
  logic [65:0] me;
  logic [31:0] d;
  logic [9:0]  c;
  logic [9:0]  codes [6];

  adcseq_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sample_code(sample_code),
    .ext_trigger(ext_trigger), .sync_in(sync_in), .sync_out(sync_out),
    .adc_clk_out(adc_clk_out), .channel_out(channel_out), .irq(irq)
  );

  // The 200 MHz clock toggles every half period.
  always #2.5 aclk = ~aclk;

  // --------------------------------------------------------------------
  // Comparison, verdict and bus tasks.
  // --------------------------------------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Writes one word; the expected response is queued for the monitor.
  task automatic wr(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] r = adcseq_pkg::RESP_OKAY);
    logic aw_ok;
    logic w_ok;
    bq.push_back(r);
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // Reads one word; mask and expected value are queued for the monitor.
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x,
                    input logic [1:0] r = adcseq_pkg::RESP_OKAY);
    rq.push_back({m, r, x});
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // Polls the start bit until the conversion in progress has ended.
  task automatic wait_idle();
    d = 32'h40;
    for (int i = 0; i < 60 && d[6]; i++) begin
      rd(adcseq_pkg::OFF_CTRL_A, 32'h0, 32'h0);
    end
  endtask

  // Measures one converter clock period for a divide setting.
  task automatic period(input int s);
    int n;
    wr(adcseq_pkg::OFF_CTRL_A, 32'h80 | s);
    while (adc_clk_out !== 1'b0) @(posedge aclk);
    while (adc_clk_out !== 1'b1) @(posedge aclk);
    n = 0;
    while (adc_clk_out !== 1'b0) begin
      @(posedge aclk);
      n++;
    end
    while (adc_clk_out !== 1'b1) begin
      @(posedge aclk);
      n++;
    end
    check(34'(n), 34'(1 << (s == 0 ? 1 : s)));
  endtask

  // --------------------------------------------------------------------
  // Monitor and timeout.
  // --------------------------------------------------------------------
  // Takes the oldest note off a queue whenever a response is handed over.
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && bq.size() > 0)
      check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0) begin
      me = rq.pop_front();
      check({s_axi_rresp, s_axi_rdata & me[65:34]}, me[33:0]);
    end
  end

  // Ends a hung run well past the expected length of all tests.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      give_verdict();
    end
  end

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(1));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    check(34'(channel_out), 34'h0);
    rd(adcseq_pkg::OFF_INPUT_SELECT, 32'hFF, 32'h00);
    rd(adcseq_pkg::OFF_CTRL_A, 32'hFF, 32'h00);
    rd(adcseq_pkg::OFF_CTRL_B, 32'hFF, 32'h00);
    wr(adcseq_pkg::OFF_INPUT_SELECT, 32'hFF);
    rd(adcseq_pkg::OFF_INPUT_SELECT, 32'hFF, 32'hEF);
    check(34'(channel_out), 34'hF);
    wr(8'h20, 32'h0, adcseq_pkg::RESP_SLVERR);
    wr(adcseq_pkg::OFF_SAMPLE_IN, 32'h0, adcseq_pkg::RESP_SLVERR);
    rd(8'h20, 32'hFFFFFFFF, 32'h0, adcseq_pkg::RESP_SLVERR);
    // Boundary differential codes and random codes in both alignments.
    codes = '{10'h1FF, 10'h000, 10'h3FF, 10'h200,
              10'($urandom()), 10'($urandom())};
    wr(adcseq_pkg::OFF_IRQ_MASK, 32'h1);
    // The converter must be on before a start write is honoured.
    wr(adcseq_pkg::OFF_CTRL_A, 32'h81);
    for (int i = 0; i < 12; i++) begin
      c = codes[i / 2];
      sample_code <= c;
      wr(adcseq_pkg::OFF_INPUT_SELECT, i[0] ? 32'h20 : 32'h00);
      wr(adcseq_pkg::OFF_CTRL_A, 32'hD1);
      wait_idle();
      rd(adcseq_pkg::OFF_CTRL_A, 32'hFF, 32'h91);
      if (i[0]) begin
        rd(adcseq_pkg::OFF_RESULT_LOW, 32'hFF, {c[1:0], 6'h0});
        rd(adcseq_pkg::OFF_RESULT_HIGH, 32'hFF, c[9:2]);
      end else begin
        rd(adcseq_pkg::OFF_RESULT_LOW, 32'hFF, c[7:0]);
        rd(adcseq_pkg::OFF_RESULT_HIGH, 32'hFF, c[9:8]);
      end
    end
    rd(adcseq_pkg::OFF_SAMPLE_IN, 32'h3FF, c);
    check(34'(irq), 34'h1);
    rd(adcseq_pkg::OFF_IRQ_STATUS, 32'hFF, 32'h1);
    wr(adcseq_pkg::OFF_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge aclk);
    check(34'(irq), 34'h0);
    wr(adcseq_pkg::OFF_IRQ_MASK, 32'h0);
    // A masked event still sets status but keeps the interrupt low.
    sync_in <= 1'b1;
    wr(adcseq_pkg::OFF_CTRL_B, 32'h80);
    wr(adcseq_pkg::OFF_CTRL_A, 32'hD1);
    wait_idle();
    check(34'(irq), 34'h0);
    rd(adcseq_pkg::OFF_IRQ_STATUS, 32'hFF, 32'h1);
    check(34'(sync_out), 34'h0);
    rd(adcseq_pkg::OFF_RESULT_HIGH, 32'h0, 32'h0);
    repeat (4) @(posedge aclk);
    check(34'(sync_out), 34'h1);
    // Free running on channel 0.
    wr(adcseq_pkg::OFF_CTRL_B, 32'h00);
    wr(adcseq_pkg::OFF_INPUT_SELECT, 32'h00);
    c = 10'($urandom());
    sample_code <= c;
    wr(adcseq_pkg::OFF_CTRL_A, 32'hE1);
    repeat (100) @(posedge aclk);
    rd(adcseq_pkg::OFF_CTRL_A, 32'h70, 32'h70);
    c = c ^ 10'h155;
    sample_code <= c;
    repeat (100) @(posedge aclk);
    rd(adcseq_pkg::OFF_RESULT_LOW, 32'hFF, c[7:0]);
    rd(adcseq_pkg::OFF_RESULT_HIGH, 32'hFF, c[9:8]);
    wr(adcseq_pkg::OFF_CTRL_A, 32'h10);
    // External trigger source with auto-trigger on.
    wr(adcseq_pkg::OFF_CTRL_B, 32'h01);
    wr(adcseq_pkg::OFF_CTRL_A, 32'h80);
    c = 10'($urandom());
    sample_code <= c;
    wr(adcseq_pkg::OFF_CTRL_A, 32'hE1);
    wait_idle();
    rd(adcseq_pkg::OFF_CTRL_A, 32'hFF, 32'hB1);
    rd(adcseq_pkg::OFF_RESULT_LOW, 32'hFF, c[7:0]);
    wr(adcseq_pkg::OFF_CTRL_A, 32'hB1);
    ext_trigger <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(adcseq_pkg::OFF_CTRL_A, 32'h40, 32'h40);
    ext_trigger <= 1'b0;
    wait_idle();
    rd(adcseq_pkg::OFF_CTRL_A, 32'hFF, 32'hB1);
    // Divide setting 7 gives 1.5625 MHz, inside the full-resolution band.
    wr(adcseq_pkg::OFF_CTRL_B, 32'h00);
    for (int s = 0; s < 8; s++) period(s);
    wr(adcseq_pkg::OFF_CTRL_A, 32'h00);
    give_verdict();
  end

endmodule // tb_top
